// File: logic/lsit_pkg.sv
// constants and types shared by the load/store issue timing block
package lsit_pkg;

   // ------------------------------------------------------------
   // register file shape
   // ------------------------------------------------------------
   localparam int          NUM_REGS = 16;
   localparam int          RS_DEPTH = 3;      // return stack entries
   localparam logic [3:0]  REG_SP   = 4'h d;
   localparam logic [3:0]  REG_PC   = 4'h f;

   // ------------------------------------------------------------
   // issue cycle counts
   // ------------------------------------------------------------
   localparam logic [3:0]  CYC_ONE       = 4'h 1;
   localparam logic [3:0]  CYC_TWO       = 4'h 2;
   localparam logic [3:0]  CYC_SWAP      = 4'h 2;
   localparam logic [3:0]  CYC_EXCEPT    = 4'h 8;
   localparam logic [3:0]  CYC_EXC_RET   = 4'h 9;
   localparam logic [3:0]  CYC_RET_HIT   = 4'h 4;
   localparam logic [3:0]  CYC_RET_MISS  = 4'h 9;
   localparam logic [3:0]  CYC_PC_NOPRED = 4'h 8;

   // ------------------------------------------------------------
   // memory cycles and latencies (in cycles, as printed)
   // ------------------------------------------------------------
   localparam logic [3:0]  MEM_ONE      = 4'h 1;
   localparam logic [3:0]  MEM_EXC_RET  = 4'h 2;
   localparam logic [3:0]  MEM_SWAP     = 4'h 2;
   localparam logic [3:0]  LAT_LOAD     = 4'h 3;
   localparam logic [3:0]  LAT_LOCK     = 4'h 1;
   localparam logic [3:0]  LAT_SYNC     = 4'h 3;
   localparam logic [3:0]  LAT_CP_READ  = 4'h 3;
   localparam logic [3:0]  LAT_BASE_WB  = 4'h 1;
   localparam logic [3:0]  LAT_EXTRA    = 4'h 1;

   // ------------------------------------------------------------
   // instruction classes seen by the issue stage
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_OTHER        = 4'h 0,  // non-memory integer instruction
      OP_DW_LOAD      = 4'h 1,  // doubleword_load
      OP_DW_STORE     = 4'h 2,  // doubleword_store
      OP_BLK_LOAD     = 4'h 3,  // block_load
      OP_BLK_STORE    = 4'h 4,  // block_store
      OP_EXC_RET      = 4'h 5,  // exception_return_load
      OP_STATE_SAVE   = 4'h 6,  // return_state_save
      OP_SWAP         = 4'h 7,  // word_swap or byte_swap
      OP_EXCL_LOAD    = 4'h 8,  // exclusive_load
      OP_EXCL_STORE   = 4'h 9,  // exclusive_store
      OP_CP_READ      = 4'h a,  // coproc_register_read
      OP_CP_READ_PAIR = 4'h b,  // coproc_register_pair_read
      OP_CP_WRITE     = 4'h c,  // coproc_register_write / coproc_data_operation
      OP_CP_MEM_LOAD  = 4'h d,  // coproc_memory_load
      OP_CP_MEM_STORE = 4'h e,  // coproc_memory_store
      OP_EXCEPT       = 4'h f   // software_interrupt_instr, breakpoint_instr, aborts
   } lsit_op_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_HOLD = 2'b10
   } lsit_state_e;

endpackage : lsit_pkg

// File: logic/lsit_reg_slot.sv
// one scoreboard slot: result latency and lock latency of one register
`timescale 1ns/1ps

module lsit_reg_slot
   import lsit_pkg::*;
#(
   parameter int CNT_W = 4
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // updates from the issue stage
   input  wire logic             set_res,
   input  wire logic [CNT_W-1:0] res_val,
   input  wire logic             set_lock,
   input  wire logic [CNT_W-1:0] lock_val,
   // slot status
   output logic                  res_busy,
   output logic                  res_late_busy,
   output logic                  lock_busy
);

   typedef struct packed {
      logic [CNT_W-1:0] res_cnt;
      logic [CNT_W-1:0] lock_cnt;
   } lsit_slot_s;

   lsit_slot_s cur;
   lsit_slot_s next_cur;

   // ------------------------------------------------------------
   // counting
   // ------------------------------------------------------------
   // counts run down each cycle; a new latency never shortens a longer one
   always_comb begin
      logic [CNT_W-1:0] res_dec;
      logic [CNT_W-1:0] lock_dec;
      res_dec  = (cur.res_cnt != '0) ? cur.res_cnt - 1'b1 : '0;
      lock_dec = (cur.lock_cnt != '0) ? cur.lock_cnt - 1'b1 : '0;
      next_cur.res_cnt  = (set_res && res_val > res_dec) ? res_val : res_dec;
      next_cur.lock_cnt = (set_lock && lock_val > lock_dec) ? lock_val : lock_dec;
   end

   // state register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   // status flags; a late operand may issue one cycle before the result
   assign res_busy      = (cur.res_cnt != '0);
   assign res_late_busy = (cur.res_cnt > CNT_W'(1));
   assign lock_busy     = (cur.lock_cnt != '0);

endmodule : lsit_reg_slot

// File: logic/lsit_issue.sv
// issue, memory-cycle and interlock timing for the load/store side
`timescale 1ns/1ps

// Behaviour
// - dword access with negative or odd-shift offset: two issue cycles, offset early only
// - dword access with constant or plain offset: one issue cycle, base and offset early
// - single-issue dword access: one memory cycle aligned, two unaligned
// - written-back base has latency one, zero to the next memory instruction
// - dword store locks its registers 1,2 single-issue or 2,3 two-issue
// - aligned dword load latency 3/3 single, 4/4 two-issue with two memory cycles
// - unaligned dword load latency 3/4 or 4/5, using two or three memory cycles
// - block transfer issues in one cycle, two registers per memory cycle, base early
// - later non-memory work proceeds unless it depends on the block transfer
// - block transfer waits until every listed register is available
// - aligned block latencies 3,3,4,4,5,5,6 and locks 1,2,2,3,3,4,4
// - unaligned block: first register alone; 3,4,4,5,5,6,6 and 1,2,2,3,4,4,5
// - block load with program counter fetches it first, all figures plus one
// - stack-based block load to program counter without status restore predicts a return
// - program counter block load: 4 hit, 9 miss/conditional/empty, 8 unpredicted
// - condition-failed program counter block load completes in one cycle
// - base of these forms needs one extra cycle of result latency
// - exception return takes 9 cycles and two memory cycles
// - state save issues in one cycle, one or two memory cycles by alignment
// - swaps 2 cycles 2 memory latency 3; exclusives 1 cycle 1 memory latency 3
// - coprocessor transfers one cycle best, reads latency 3, coprocessor sets words
// - exception instructions take 8 cycles; condition-failed take one, some undefined two
module lsit_issue
   import lsit_pkg::*;
#(
   parameter int ADDR_W = 32
) (
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // decoded instruction from the issue stage
   input  wire logic              in_valid,
   input  wire lsit_op_e          in_op,
   input  wire logic              in_cond_fail,
   input  wire logic              in_is_cond,
   input  wire logic              in_neg_offset,
   input  wire logic              in_shift_other,
   input  wire logic              in_reg_offset,
   input  wire logic              in_dw_aligned,
   input  wire logic              in_two_issue,
   input  wire logic              in_writeback,
   input  wire logic              in_restore_status,
   input  wire logic              in_undef_two,
   input  wire logic [3:0]        in_base,
   input  wire logic [3:0]        in_offset,
   input  wire logic [3:0]        in_rd,
   input  wire logic [15:0]       in_reg_list,
   input  wire logic [15:0]       in_src_mask,
   input  wire logic [15:0]       in_dst_mask,
   input  wire logic [3:0]        in_cp_words,
   input  wire logic [ADDR_W-1:0] in_ret_target,
   output logic                   in_ready,
   // return stack fill from the fetch side
   input  wire logic              push_valid,
   input  wire logic [ADDR_W-1:0] push_addr,
   // timing status
   output logic                   issue_busy,
   output logic                   mem_active,
   output logic [3:0]             cycles_taken,
   output logic                   ret_hit,
   output logic                   ret_miss
);

   typedef struct packed {
      lsit_state_e                     st;
      logic [3:0]                      busy_left;
      logic [3:0]                      mem_left;
      logic [RS_DEPTH-1:0][ADDR_W-1:0] rs;
      logic [1:0]                      rs_cnt;
      logic [3:0]                      fwd_base;
      logic                            fwd_valid;
      logic [3:0]                      cycles;
      logic                            hit;
      logic                            miss;
   } lsit_state_s;

   lsit_state_s cur;
   lsit_state_s next_cur;

   logic [NUM_REGS-1:0] res_busy;
   logic [NUM_REGS-1:0] res_late_busy;
   logic [NUM_REGS-1:0] lock_busy;
   logic [NUM_REGS-1:0] set_res;
   logic [NUM_REGS-1:0] set_lock;
   logic [3:0]          res_val  [NUM_REGS];
   logic [3:0]          lock_val [NUM_REGS];
   logic [15:0]         rd_early;
   logic [15:0]         rd_late;
   logic [15:0]         wr_mask;
   logic                is_mem;
   logic                hazard;
   logic                fire;
   logic [3:0]          cyc;
   logic [3:0]          mem;

   // ------------------------------------------------------------
   // scoreboard
   // ------------------------------------------------------------
   // one slot per register
   for (genvar g = 0; g < NUM_REGS; g++) begin : g_slot
      lsit_reg_slot #(.CNT_W(4)) u_slot (
         .ref_clk       (ref_clk),
         .rst           (rst),
         .set_res       (set_res[g]),
         .res_val       (res_val[g]),
         .set_lock      (set_lock[g]),
         .lock_val      (lock_val[g]),
         .res_busy      (res_busy[g]),
         .res_late_busy (res_late_busy[g]),
         .lock_busy     (lock_busy[g])
      );
   end

   // ------------------------------------------------------------
   // operand masks and hazard check
   // ------------------------------------------------------------
   // which registers must be ready early, late, or free to write
   always_comb begin
      logic [3:0] rd_hi;
      rd_hi    = in_rd + 4'h 1;
      rd_early = '0;
      rd_late  = '0;
      wr_mask  = in_dst_mask;
      is_mem   = (in_op != OP_OTHER) && (in_op != OP_EXCEPT);
      case (in_op)
         OP_DW_LOAD, OP_DW_STORE: begin
            if (in_neg_offset || in_shift_other) begin
               // offset early, base one cycle later
               rd_early[in_offset] = 1'b1;
               rd_late[in_base]    = 1'b1;
            end else begin
               rd_early[in_base] = 1'b1;
               if (in_reg_offset) begin
                  rd_early[in_offset] = 1'b1;
               end
            end
            if (in_op == OP_DW_STORE) begin
               rd_late[in_rd] = 1'b1;
               rd_late[rd_hi] = 1'b1;
            end else begin
               wr_mask[in_rd] = 1'b1;
               wr_mask[rd_hi] = 1'b1;
            end
         end
         OP_BLK_LOAD, OP_BLK_STORE: begin
            // every listed register must be settled first
            rd_early          = in_reg_list;
            wr_mask           = in_reg_list;
            rd_early[in_base] = 1'b1;
         end
         OP_OTHER, OP_EXCEPT: begin
            // source dependencies and locked destinations hold non-memory work
            rd_early = in_src_mask;
         end
         default: begin
            // base early for the remaining memory forms
            rd_early          = in_src_mask;
            rd_early[in_base] = 1'b1;
         end
      endcase
      // back-to-back memory instruction sees the new base at once
      if (is_mem && cur.fwd_valid && in_base == cur.fwd_base) begin
         rd_early[in_base] = 1'b0;
         rd_late[in_base]  = 1'b0;
      end
   end

   // stall while any relevant count is still running
   assign hazard = |(rd_early & res_busy) | |(rd_late & res_late_busy) | |(wr_mask & lock_busy);
   // a memory instruction also waits for the data path to drain
   assign in_ready = (cur.st == ST_IDLE) && !hazard && !(is_mem && cur.mem_left != 4'h 0);
   assign fire     = in_valid && in_ready;

   // ------------------------------------------------------------
   // cycle, memory and latency figures of the offered instruction
   // ------------------------------------------------------------
   always_comb begin
      logic [3:0] k;
      logic [3:0] n;
      logic [3:0] lat;
      logic [3:0] lk;
      logic [3:0] dw_lat;
      logic [3:0] bw_lat;
      logic       pc_in;
      logic       predict;
      logic       top_hit;
      k       = '0;
      n       = '0;
      lat     = '0;
      lk      = '0;
      pc_in   = in_reg_list[REG_PC];
      predict = (in_base == REG_SP) && !in_restore_status;
      top_hit = (cur.rs_cnt != 2'd0) && (cur.rs[0] == in_ret_target) && !in_is_cond;
      dw_lat  = LAT_LOAD + {3'b000, in_two_issue};
      bw_lat  = LAT_BASE_WB;
      set_res  = '0;
      set_lock = '0;
      for (int i = 0; i < NUM_REGS; i++) begin
         res_val[i]  = '0;
         lock_val[i] = '0;
      end
      n = 4'(in_reg_list[14:0] != '0 ? $countones(in_reg_list[14:0]) : 0);
      cyc = CYC_ONE;
      mem = '0;
      case (in_op)
         OP_DW_LOAD, OP_DW_STORE: begin
            // two issue cycles for the slow offset forms
            cyc = (in_neg_offset || in_shift_other) ? CYC_TWO : CYC_ONE;
            // extra memory cycle when not doubleword aligned
            mem = MEM_ONE + {3'b000, in_two_issue} + {3'b000, !in_dw_aligned};
            if (in_op == OP_DW_LOAD) begin
               // unaligned second register one cycle later
               set_res[in_rd]         = 1'b1;
               res_val[in_rd]         = dw_lat - 4'h 1;
               set_res[in_rd + 4'h 1] = 1'b1;
               res_val[in_rd + 4'h 1] = dw_lat + {3'b000, !in_dw_aligned} - 4'h 1;
            end else begin
               // stored pair locked 1,2 or 2,3
               set_lock[in_rd]         = 1'b1;
               lock_val[in_rd]         = LAT_LOCK + {3'b000, in_two_issue} - 4'h 1;
               set_lock[in_rd + 4'h 1] = 1'b1;
               lock_val[in_rd + 4'h 1] = LAT_LOCK + {3'b000, in_two_issue};
            end
         end
         OP_BLK_LOAD, OP_BLK_STORE: begin
            // two registers per memory cycle, one issue cycle
            mem = in_dw_aligned ? (n + 4'h 1) >> 1 : (n >> 1) + 4'h 1;
            for (int i = 0; i < NUM_REGS - 1; i++) begin
               if (in_reg_list[i]) begin
                  // unaligned figures step after the lone first
                  lat = in_dw_aligned ? LAT_LOAD + (k >> 1) : LAT_LOAD + ((k + 4'h 1) >> 1);
                  if (in_dw_aligned || k < 4'h 4) begin
                     lk = LAT_LOCK + ((k + 4'h 1) >> 1);
                  end else begin
                     lk = LAT_LOCK + 4'h 1 + (k >> 1);
                  end
                  // program counter first pushes every latency by one
                  if (in_op == OP_BLK_LOAD) begin
                     set_res[i] = 1'b1;
                     res_val[i] = lat + {3'b000, pc_in} - 4'h 1;
                  end else begin
                     set_lock[i] = 1'b1;
                     lock_val[i] = lk - 4'h 1;
                  end
                  k = k + 4'h 1;
               end
            end
            if (in_op == OP_BLK_LOAD && pc_in) begin
               // one more memory cycle for the program counter
               mem = mem + 4'h 1;
               bw_lat = LAT_BASE_WB + LAT_EXTRA;
               // return prediction on the stack-based form
               if (!predict) begin
                  cyc = CYC_PC_NOPRED;
               end else if (top_hit) begin
                  cyc = CYC_RET_HIT;
               end else begin
                  cyc = CYC_RET_MISS;
               end
            end
         end
         OP_EXC_RET: begin
            cyc    = CYC_EXC_RET;
            mem    = MEM_EXC_RET;
            bw_lat = LAT_BASE_WB + LAT_EXTRA;
         end
         OP_STATE_SAVE: begin
            // alignment decides one or two memory cycles
            mem    = in_dw_aligned ? MEM_ONE : MEM_ONE + 4'h 1;
            bw_lat = LAT_BASE_WB + LAT_EXTRA;
         end
         OP_SWAP, OP_EXCL_LOAD, OP_EXCL_STORE: begin
            cyc             = (in_op == OP_SWAP) ? CYC_SWAP : CYC_ONE;
            mem             = (in_op == OP_SWAP) ? MEM_SWAP : MEM_ONE;
            set_res[in_rd]  = 1'b1;
            res_val[in_rd]  = LAT_SYNC - 4'h 1;
            bw_lat          = LAT_BASE_WB + LAT_EXTRA;
         end
         OP_CP_READ, OP_CP_READ_PAIR: begin
            // coprocessor reads return after three cycles
            mem            = MEM_ONE;
            set_res[in_rd] = 1'b1;
            res_val[in_rd] = LAT_CP_READ - 4'h 1;
            if (in_op == OP_CP_READ_PAIR) begin
               set_res[in_rd + 4'h 1] = 1'b1;
               res_val[in_rd + 4'h 1] = LAT_CP_READ - 4'h 1;
            end
         end
         OP_CP_WRITE: begin
            mem = MEM_ONE;
         end
         OP_CP_MEM_LOAD, OP_CP_MEM_STORE: begin
            // the coprocessor supplies the word count
            mem = in_cp_words;
         end
         OP_EXCEPT: begin
            // exception taken at the writeback stage
            cyc = CYC_EXCEPT;
         end
         default: begin
            cyc = CYC_ONE;
         end
      endcase
      if (in_writeback && is_mem) begin
         set_res[in_base] = 1'b1;
         res_val[in_base] = bw_lat - 4'h 1;
      end
      if (in_cond_fail) begin
         cyc      = (in_op == OP_EXCEPT && in_undef_two) ? CYC_TWO : CYC_ONE;
         mem      = '0;
         set_res  = '0;
         set_lock = '0;
      end
      // only an accepted instruction touches the scoreboard
      if (!fire) begin
         set_res  = '0;
         set_lock = '0;
      end
   end

   // ------------------------------------------------------------
   // sequencing and return stack
   // ------------------------------------------------------------
   always_comb begin
      logic pop;
      pop = fire && !in_cond_fail && in_op == OP_BLK_LOAD && in_reg_list[REG_PC]
            && in_base == REG_SP && !in_restore_status;
      next_cur      = cur;
      next_cur.hit  = 1'b0;
      next_cur.miss = 1'b0;
      if (cur.mem_left != 4'h 0) begin
         next_cur.mem_left = cur.mem_left - 4'h 1;
      end
      case (cur.st)
         ST_IDLE: begin
            if (fire) begin
               next_cur.cycles    = cyc;
               next_cur.mem_left  = is_mem ? mem : next_cur.mem_left;  // block transfer keeps running
               next_cur.busy_left = cyc - 4'h 1;
               next_cur.fwd_valid = is_mem && in_writeback && !in_cond_fail;
               next_cur.fwd_base  = in_base;
               if (cyc > CYC_ONE) begin
                  next_cur.st = ST_HOLD;
               end
            end
         end
         ST_HOLD: begin
            next_cur.busy_left = cur.busy_left - 4'h 1;
            if (cur.busy_left == 4'h 1) begin
               next_cur.st = ST_IDLE;
            end
         end
         default: begin
            next_cur.st = ST_IDLE;
         end
      endcase
      // pop on a predicted return, reporting the outcome
      if (pop) begin
         next_cur.hit  = (cyc == CYC_RET_HIT);
         next_cur.miss = (cyc != CYC_RET_HIT);
         if (cur.rs_cnt != 2'd0) begin
            next_cur.rs     = cur.rs >> ADDR_W;
            next_cur.rs_cnt = cur.rs_cnt - 2'd1;
         end
      end else if (push_valid) begin
         // oldest entry falls off when the stack is full
         next_cur.rs     = {cur.rs[RS_DEPTH-2:0], push_addr};
         next_cur.rs_cnt = (cur.rs_cnt == 2'(RS_DEPTH)) ? cur.rs_cnt : cur.rs_cnt + 2'd1;
      end
   end

   // state register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cur    <= '0;
         cur.st <= ST_IDLE;
      end else begin
         cur <= next_cur;
      end
   end

   // status outputs straight from flops
   assign issue_busy   = (cur.st == ST_HOLD);
   assign mem_active   = (cur.mem_left != 4'h 0);
   assign cycles_taken = cur.cycles;
   assign ret_hit      = cur.hit;
   assign ret_miss     = cur.miss;

endmodule : lsit_issue

// File: tb/lsit_asserts.sv
// checker for load/store issue timing
`timescale 1ns/1ps
module lsit_asserts
   import lsit_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       in_valid,
   input wire lsit_op_e   in_op,
   input wire logic       in_cond_fail,
   input wire logic       in_dw_aligned,
   input wire logic       in_ready,
   input wire logic       issue_busy,
   input wire logic       mem_active,
   input wire logic [3:0] cycles_taken,
   input wire logic       ret_hit,
   input wire logic       ret_miss
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // accepted and condition passed
   wire tk = in_valid && in_ready && !in_cond_fail;
   sequence s_m1; mem_active ##1 !mem_active; endsequence
   sequence s_m2; mem_active [*2] ##1 !mem_active; endsequence
   a_swap_two: assert property (tk && in_op == OP_SWAP |=> cycles_taken == 4'h2 ##0 s_m2)
      else $error("swap timing wrong");
   a_excl_one: assert property (tk && (in_op == OP_EXCL_LOAD || in_op == OP_EXCL_STORE)
      |=> cycles_taken == 4'h1 ##0 s_m1)
      else $error("exclusive timing wrong");
   a_exc_ret: assert property (tk && in_op == OP_EXC_RET
      |=> cycles_taken == 4'h9 ##0 s_m2) else $error("exception return timing wrong");
   a_save_al: assert property (tk && in_op == OP_STATE_SAVE && in_dw_aligned
      |=> cycles_taken == 4'h1 ##0 s_m1)
      else $error("aligned state save wrong");
   a_save_un: assert property (tk && in_op == OP_STATE_SAVE && !in_dw_aligned
      |=> cycles_taken == 4'h1 ##0 s_m2)
      else $error("unaligned state save wrong");
   a_exc_eight: assert property (tk && in_op == OP_EXCEPT
      |=> cycles_taken == 4'h8 && !mem_active) else $error("exception instruction timing wrong");
   a_exc_busy: assert property (tk && in_op == OP_EXCEPT
      |=> issue_busy [*7] ##1 !issue_busy) else $error("exception hold length wrong");
   a_fail_one: assert property (in_valid && in_ready && in_cond_fail && in_op != OP_EXCEPT
      |=> cycles_taken == 4'h1 && !mem_active)
      else $error("condition failed timing wrong");
   a_busy_hold: assert property (issue_busy |-> !in_ready)
      else $error("accept while busy");
   a_ret_excl: assert property (!(ret_hit && ret_miss))
      else $error("hit and miss together");
endmodule : lsit_asserts
bind lsit_issue lsit_asserts u_chk (.*);

// File: tb/lsit_far_model.sv
// far-side model: coprocessor word count and return-stack fill
`timescale 1ns/1ps
module lsit_far_model #(
   parameter int CP_WORDS = 3
) (
   input  wire logic   ref_clk,
   output logic [3:0]  in_cp_words,
   output logic        push_valid,
   output logic [31:0] push_addr
);
   assign in_cp_words = 4'(CP_WORDS);
   initial push_valid = 1'b0;
   initial push_addr = 32'h0000_0000;
   // one-cycle push; address inverted after so nothing stale lingers
   task automatic push(input logic [31:0] a);
      @(posedge ref_clk);
      #1 push_valid = 1'b1;
      push_addr = a;
      @(posedge ref_clk);
      #1 push_valid = 1'b0;
      push_addr = ~a;
   endtask : push
endmodule : lsit_far_model

// File: tb/tb_load_store_issue_timing.sv
// self-checking bench for load/store issue timing
`timescale 1ns/1ps
module tb_load_store_issue_timing;
   import lsit_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1, in_valid = 1'b0, in_cond_fail = 1'b0, in_is_cond = 1'b0;
   logic in_neg_offset = 1'b0, in_shift_other = 1'b0, in_reg_offset = 1'b1, in_dw_aligned = 1'b1;
   logic in_two_issue = 1'b0, in_writeback = 1'b0, in_restore_status = 1'b0, in_undef_two = 1'b1;
   logic [3:0] in_base = 4'h0, in_offset = 4'h0, in_rd = 4'h4, in_cp_words, cycles_taken;
   logic [15:0] in_reg_list = 16'h8002, in_src_mask = 16'h0000, in_dst_mask = 16'h0000;
   logic [31:0] in_ret_target = 32'h0000_1230, push_addr;
   logic in_ready, push_valid, issue_busy, mem_active, ret_hit, ret_miss;
   lsit_op_e in_op = OP_OTHER;
   int err_count = 0, checks_done = 0, cyc = 0, t0, t1;
   lsit_far_model far (.*);
   lsit_issue uut (.*);
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 1;
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // offer until taken; valid stays up so back-to-back offers work
   task automatic go(output int t);
      in_valid = 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(negedge ref_clk);
         if (in_ready === 1'b1) break;
      end
      @(posedge ref_clk);
      t = cyc;
      #1;
   endtask : go
   // release valid, check cycle count and count memory cycles
   task automatic meas(input logic [3:0] ec, input logic [3:0] em);
      logic [3:0] m;
      m = 4'h0;
      in_valid = 1'b0;
      @(negedge ref_clk);
      chk(cycles_taken, ec);
      while (mem_active === 1'b1 && m < 4'hf) begin
         m++;
         @(negedge ref_clk);
      end
      chk(m, em);
      @(posedge ref_clk);
      #1;
   endtask : meas
   task automatic t_table();
      lsit_op_e op [9] = '{OP_SWAP, OP_EXCL_LOAD, OP_EXCL_STORE, OP_EXC_RET, OP_STATE_SAVE,
         OP_CP_MEM_LOAD, OP_EXCEPT, OP_EXCEPT, OP_BLK_LOAD};
      logic [3:0] ec [9] = '{4'h2, 4'h1, 4'h1, 4'h9, 4'h1, 4'h1, 4'h8, 4'h2, 4'h1};
      logic [3:0] em [9] = '{4'h2, 4'h1, 4'h1, 4'h2, 4'h1, 4'h3, 4'h0, 4'h0, 4'h0};
      foreach (op[i]) begin
         in_op = op[i];
         in_cond_fail = (i > 6);
         go(t0);
         meas(ec[i], em[i]);
      end
      in_cond_fail = 1'b0;
   endtask : t_table
   // dword load then reader of its second register
   task automatic t_dword();
      for (int i = 0; i < 4; i++) begin
         {in_neg_offset, in_dw_aligned} = 2'(i);
         in_shift_other = in_neg_offset;
         in_two_issue = in_neg_offset;
         in_op = OP_DW_LOAD;
         go(t0);
         in_op = OP_OTHER;
         in_src_mask = 16'h0020;
         go(t1);
         chk(4'(t1 - t0), 4'(3 + in_neg_offset + !in_dw_aligned));
         meas(4'h1, 4'h0);
      end
      // two-issue store pair locks 2,3; writer of the second register waits
      in_op = OP_DW_STORE;
      go(t0);
      in_op = OP_OTHER;
      in_dst_mask = 16'h0020;
      go(t1);
      chk(4'(t1 - t0), 4'h3);
      meas(4'h1, 4'h0);
      in_src_mask = 16'h0000;
   endtask : t_dword
   // block transfer r1-r7 then dependent or free instruction
   task automatic t_block();
      logic [15:0] mk [5] = '{16'h0008, 16'h0004, 16'h0040, 16'h0020, 16'h0400};
      logic [3:0] el [5] = '{4'h4, 4'h4, 4'h4, 4'h4, 4'h1};
      foreach (mk[i]) begin
         in_op = (i == 2 || i == 3) ? OP_BLK_STORE : OP_BLK_LOAD;
         in_dw_aligned = (i != 1 && i != 3);
         in_reg_list = 16'h00fe;
         go(t0);
         in_src_mask = (in_op == OP_BLK_LOAD) ? mk[i] : 16'h0000;
         in_dst_mask = (in_op == OP_BLK_LOAD) ? 16'h0000 : mk[i];
         in_op = OP_OTHER;
         go(t1);
         chk(4'(t1 - t0), el[i]);
         meas(4'h1, (i == 4) ? 4'h3 : 4'h0);
      end
      in_dst_mask = 16'h0000;
      in_src_mask = 16'h0000;
   endtask : t_block
   // return prediction: hit, empty stack, non-stack base
   task automatic t_ret();
      logic [3:0] ec [3] = '{4'h4, 4'h9, 4'h8};
      logic [3:0] eh [3] = '{4'h6, 4'h5, 4'h4};
      far.push(32'h0000_1230);
      in_reg_list = 16'h8010;
      in_dw_aligned = 1'b1;
      foreach (ec[i]) begin
         in_op = OP_BLK_LOAD;
         in_base = (i == 2) ? 4'h0 : REG_SP;
         go(t0);
         chk({1'b0, issue_busy, ret_hit, ret_miss}, eh[i]);
         meas(ec[i], 4'h2);
      end
   endtask : t_ret
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up
   initial begin
      #75000;
      err_count++;
      wrap_up();
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      #1 rst = 1'b0;
      t_table();
      t_dword();
      t_block();
      t_ret();
      wrap_up();
   end
endmodule : tb_load_store_issue_timing
